// file: rtl/paired_32bit_timer.sv
// two 16-bit timers that chain into one 32-bit timer, apb register slave
// assumes pins synchronous to i_clk_sys; i_idle is high while the processor idles
//
// The address map and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
module paired_32bit_timer
	import paired_timer_pkg::*;
#(
	parameter int ADDR_W = 12
)(
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_clk_en,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_idle,
	input wire logic i_ext_clk_lo,
	input wire logic i_ext_clk_hi,
	output logic o_irq
);
	// the highest register index must fit the address bus
	if (ADDR_W < `IDX_W + 2)
	begin : g_bad_addr
		$error("ADDR_W too small for register map");
	end

	// the pair is built as two 16-bit halves of one 32-bit word
	// a wider half would overflow the zero-extended step and the read word
	if (`TMR_W != 16)
	begin : g_bad_tmr_w
		$error("timer width must be 16");
	end

	// prescale select is decoded as two adjacent control bits
	if (`CON_PS_HI != `CON_PS_LO + 1)
	begin : g_bad_ps_field
		$error("prescale field must be two adjacent bits");
	end

	// status and mask are packed into the low two bits of a read word
	if (`IRQ_W != 2)
	begin : g_bad_irq_w
		$error("status width must be 2");
	end

	core_state_t s_r;
	core_state_t s_nxt;
	timer_tick_if lo_if ();
	timer_tick_if hi_if ();
	logic pair;
	logic setup;
	logic acc;
	logic [`IDX_W-1:0] idx;
	logic [31:0] per32;
	logic [31:0] cnt32;
	logic [`IRQ_W-1:0] set_ev;
	logic wr_acc;
	logic rd_setup;
	logic tick_lo;
	logic tick_hi;
	logic fall_lo;
	logic fall_hi;
	logic match_lo;
	logic match_hi;
	logic match32;
	logic [31:0] nxt32;
	logic [15:0] nxt_lo;
	logic [15:0] nxt_hi;

	// register map by index, the byte address is four times the index:
	//   low count, upper word hold, high count
	//   low period, high period
	//   low control, high control
	//   interrupt status (write one to clear), interrupt mask
	// control word: bit 15 on, 13 idle stop, 6 gate, 5:4 prescale, 3 pair, 1 external
	// the pair bit exists in the low control only; the high control never chains
	// status and mask: bit 0 low timer, bit 1 high timer or the pair
	// the hold register only matters while paired, but stays readable always

	// register index decode, byte address is four times the index
	function automatic logic [`IDX_W-1:0] to_idx(input logic [ADDR_W-1:0] a);
		return a[`IDX_W+1:2];
	endfunction

	// index lies on the map
	function automatic logic is_mapped(input logic [`IDX_W-1:0] i);
		case (i)
			`IDX_LO_CNT, `IDX_HOLD, `IDX_HI_CNT, `IDX_LO_PER, `IDX_HI_PER,
			`IDX_LO_CON, `IDX_HI_CON, `IDX_IRQ_STAT, `IDX_IRQ_MASK: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// one counter step: wrap to zero on period match, else increment
	function automatic logic [31:0] step(input logic [31:0] c, input logic [31:0] p);
		return (c == p) ? 32'h0000_0000 : c + 32'h0000_0001;
	endfunction

	assign pair = s_r.con_lo[`CON_PAIR];
	assign setup = i_psel && !i_penable;
	assign acc = i_psel && i_penable;
	assign idx = to_idx(i_paddr);
	assign cnt32 = {s_r.cnt_hi, s_r.cnt_lo};
	assign per32 = {s_r.per_hi, s_r.per_lo};

	// bus phases: read data is captured at setup, writes commit at access
	assign rd_setup = setup && !i_pwrite;
	assign wr_acc = acc && i_pwrite;

	// tick and gate-end events of both halves
	assign tick_lo = lo_if.tick;
	assign tick_hi = hi_if.tick;
	assign fall_lo = lo_if.gate_fall;
	assign fall_hi = hi_if.gate_fall;

	// period matches; a 16-bit half compares only its own word
	assign match_lo = (s_r.cnt_lo == s_r.per_lo);
	assign match_hi = (s_r.cnt_hi == s_r.per_hi);
	assign match32 = (cnt32 == per32);

	// next counts; a half goes through the 32-bit step zero-extended and cut back
	assign nxt32 = step(cnt32, per32);
	assign nxt_lo = 16'(step({16'h0000, s_r.cnt_lo}, {16'h0000, s_r.per_lo}));
	assign nxt_hi = 16'(step({16'h0000, s_r.cnt_hi}, {16'h0000, s_r.per_hi}));

	// low tick unit always steered by low control
	assign lo_if.on = s_r.con_lo[`CON_ON];
	assign lo_if.ext_sel = s_r.con_lo[`CON_EXT];
	assign lo_if.gate_en = s_r.con_lo[`CON_GATE];
	assign lo_if.ps_sel = s_r.con_lo[`CON_PS_HI:`CON_PS_LO];
	assign lo_if.idle_stop = s_r.con_lo[`CON_IDLE_STOP];
	assign lo_if.clr = s_r.clr_lo;
	assign lo_if.ext_clk = i_ext_clk_lo;
	assign lo_if.gate_pin = i_ext_clk_lo;
	assign lo_if.idle = i_idle;

	// high unit is held off while paired, so its control has no effect
	assign hi_if.on = s_r.con_hi[`CON_ON] && !pair;
	assign hi_if.ext_sel = s_r.con_hi[`CON_EXT];
	assign hi_if.gate_en = s_r.con_hi[`CON_GATE];
	assign hi_if.ps_sel = s_r.con_hi[`CON_PS_HI:`CON_PS_LO];
	assign hi_if.idle_stop = s_r.con_hi[`CON_IDLE_STOP];
	assign hi_if.clr = s_r.clr_hi;
	assign hi_if.ext_clk = i_ext_clk_hi;
	assign hi_if.gate_pin = i_ext_clk_hi;
	assign hi_if.idle = i_idle;

	timer_tick_unit #(
		.SYNC_OUT(1'b1)
	) u_lo (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.i_clk_en(i_clk_en),
		.t(lo_if)
	);

	timer_tick_unit #(
		.SYNC_OUT(1'b0)
	) u_hi (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.i_clk_en(i_clk_en),
		.t(hi_if)
	);

	// counting, register access and interrupt flags
	always_comb
	begin
		s_nxt = s_r;
		set_ev = '0;
		s_nxt.clr_lo = 1'b0;
		s_nxt.clr_hi = 1'b0;

		// counting; a same-cycle software write below takes precedence
		if (pair)
		begin
			// the pair wraps only on the full 32-bit match
			if (tick_lo)
			begin
				{s_nxt.cnt_hi, s_nxt.cnt_lo} = nxt32;
				set_ev[`IRQ_HI] = match32;
			end
			if (fall_lo)
				set_ev[`IRQ_HI] = 1'b1;
		end
		else
		begin
			// each half runs on its own tick and period
			if (tick_lo)
			begin
				s_nxt.cnt_lo = nxt_lo;
				set_ev[`IRQ_LO] = match_lo;
			end
			if (tick_hi)
			begin
				s_nxt.cnt_hi = nxt_hi;
				set_ev[`IRQ_HI] = match_hi;
			end
			if (fall_lo)
				set_ev[`IRQ_LO] = 1'b1;
			if (fall_hi)
				set_ev[`IRQ_HI] = 1'b1;
		end

		// read data is taken in the setup cycle so the access phase needs no wait
		if (rd_setup)
		begin
			case (idx)
				`IDX_LO_CNT:
				begin
					s_nxt.prdata = {16'h0000, s_r.cnt_lo};
					s_nxt.hold = s_r.cnt_hi;
				end
				`IDX_HOLD: s_nxt.prdata = {16'h0000, s_r.hold};
				`IDX_HI_CNT: s_nxt.prdata = {16'h0000, s_r.cnt_hi};
				`IDX_LO_PER: s_nxt.prdata = {16'h0000, s_r.per_lo};
				`IDX_HI_PER: s_nxt.prdata = {16'h0000, s_r.per_hi};
				`IDX_LO_CON: s_nxt.prdata = {16'h0000, s_r.con_lo};
				`IDX_HI_CON: s_nxt.prdata = {16'h0000, s_r.con_hi};
				`IDX_IRQ_STAT: s_nxt.prdata = {30'h0000_0000, s_r.stat};
				`IDX_IRQ_MASK: s_nxt.prdata = {30'h0000_0000, s_r.mask};
				default: s_nxt.prdata = 32'h0000_0000;
			endcase
		end

		// writes take effect at the access edge; stat is write-one-to-clear
		if (wr_acc)
		begin
			case (idx)
				`IDX_LO_CNT:
				begin
					s_nxt.cnt_lo = i_pwdata[15:0];
					s_nxt.clr_lo = 1'b1;
					if (pair)
					begin
						s_nxt.cnt_hi = s_r.hold;
						s_nxt.clr_hi = 1'b1;
					end
				end
				`IDX_HOLD: s_nxt.hold = i_pwdata[15:0];
				`IDX_HI_CNT:
				begin
					s_nxt.cnt_hi = i_pwdata[15:0];
					s_nxt.clr_hi = 1'b1;
					s_nxt.clr_lo = pair;
				end
				`IDX_LO_PER: s_nxt.per_lo = i_pwdata[15:0];
				`IDX_HI_PER: s_nxt.per_hi = i_pwdata[15:0];
				`IDX_LO_CON: s_nxt.con_lo = i_pwdata[15:0] & `CON_LO_MASK;
				`IDX_HI_CON: s_nxt.con_hi = i_pwdata[15:0] & `CON_HI_MASK;
				`IDX_IRQ_STAT: s_nxt.stat = s_r.stat & ~i_pwdata[`IRQ_W-1:0];
				`IDX_IRQ_MASK: s_nxt.mask = i_pwdata[`IRQ_W-1:0];
				default: ;
			endcase
		end

		// a hardware event in the clearing cycle still sets its flag
		s_nxt.stat = s_nxt.stat | set_ev;
	end

	// zero-wait slave; unmapped indices answer with an error
	assign o_pready = 1'b1;
	assign o_pslverr = acc && !is_mapped(idx);
	assign o_prdata = s_r.prdata;
	// high enable gates the pair's interrupt, low enable only serves the low timer
	assign o_irq = |(s_r.stat & s_r.mask);

	// state register; periods reset to all ones so a fresh timer spans the full range
	// a low clock enable freezes counting and bus writes alike
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			s_r <= '0;
			s_r.per_lo <= `RST_PER;
			s_r.per_hi <= `RST_PER;
			s_r.con_lo <= `RST_CON;
			s_r.con_hi <= `RST_CON;
			s_r.cnt_lo <= `RST_CNT;
			s_r.cnt_hi <= `RST_CNT;
		end
		else if (i_clk_en)
			s_r <= s_nxt;
	end
endmodule
`default_nettype wire

// file: shared/paired_timer_params.svh
// register indices, field positions, reset values and prescale counts of the paired timer
// assumes byte address = 4 * index on a 32-bit apb bus
`ifndef PAIRED_TIMER_PARAMS_SVH
`define PAIRED_TIMER_PARAMS_SVH
`define TMR_W 16
`define IDX_W 10
// register indices, byte address is four times the index
`define IDX_LO_CNT 10'h106
`define IDX_HOLD 10'h108
`define IDX_HI_CNT 10'h10A
`define IDX_LO_PER 10'h10C
`define IDX_HI_PER 10'h10E
`define IDX_LO_CON 10'h110
`define IDX_HI_CON 10'h112
`define IDX_IRQ_STAT 10'h114
`define IDX_IRQ_MASK 10'h116
// control field positions
`define CON_ON 15
`define CON_IDLE_STOP 13
`define CON_GATE 6
`define CON_PS_HI 5
`define CON_PS_LO 4
`define CON_PAIR 3
`define CON_EXT 1
// implemented control bits, the rest read as zero
`define CON_LO_MASK 16'hA07A
`define CON_HI_MASK 16'hA072
// reset values
`define RST_CNT 16'h0000
`define RST_PER 16'hFFFF
`define RST_CON 16'h0000
// prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define PS_W 8
`define PS_END1 8'h00
`define PS_END8 8'h07
`define PS_END64 8'h3F
`define PS_END256 8'hFF
// status and mask bit positions
`define IRQ_LO 0
`define IRQ_HI 1
`define IRQ_W 2
`endif

// file: shared/paired_timer_pkg.sv
// types of the paired timer: state records of the tick unit and of the core
// assumes the params header is on the include path
`include "paired_timer_params.svh"
package paired_timer_pkg;
	typedef struct packed {
		logic ext_q;
		logic gate_q;
		logic [`PS_W-1:0] pcnt;
		logic tick;
		logic gate_fall;
	} tick_state_t;

	typedef struct packed {
		logic [`TMR_W-1:0] cnt_lo;
		logic [`TMR_W-1:0] cnt_hi;
		logic [`TMR_W-1:0] hold;
		logic [`TMR_W-1:0] per_lo;
		logic [`TMR_W-1:0] per_hi;
		logic [`TMR_W-1:0] con_lo;
		logic [`TMR_W-1:0] con_hi;
		logic [`IRQ_W-1:0] stat;
		logic [`IRQ_W-1:0] mask;
		logic [31:0] prdata;
		logic clr_lo;
		logic clr_hi;
	} core_state_t;
endpackage

// file: shared/timer_tick_if.sv
// carrier between the timer core and one tick unit
// assumes both ends sit on the same clock
`timescale 1ns/100ps
`default_nettype none
interface timer_tick_if;
	logic on;
	logic ext_sel;
	logic gate_en;
	logic [1:0] ps_sel;
	logic idle_stop;
	logic clr;
	logic ext_clk;
	logic gate_pin;
	logic idle;
	logic tick;
	logic gate_fall;
	modport core (output on, ext_sel, gate_en, ps_sel, idle_stop, clr, ext_clk, gate_pin, idle,
		input tick, gate_fall);
	modport unit (input on, ext_sel, gate_en, ps_sel, idle_stop, clr, ext_clk, gate_pin, idle,
		output tick, gate_fall);
endinterface
`default_nettype wire

// file: rtl/timer_tick_unit.sv
// clock source select, gate, idle stop and prescaler of one 16-bit timer
// assumes pins are synchronous to i_clk_sys; emits one-cycle count ticks
`timescale 1ns/100ps
`default_nettype none
module timer_tick_unit
	import paired_timer_pkg::*;
#(
	parameter bit SYNC_OUT = 1'b1
)(
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_clk_en,
	timer_tick_if.unit t
);
	tick_state_t s_r;
	tick_state_t s_nxt;
	logic [`PS_W-1:0] ps_end;
	logic src;
	logic run;
	logic raw;

	// terminal count of the prescaler
	always_comb
	begin
		case (t.ps_sel)
			2'h0: ps_end = `PS_END1;
			2'h1: ps_end = `PS_END8;
			2'h2: ps_end = `PS_END64;
			default: ps_end = `PS_END256;
		endcase
	end

	// external edge or gated internal cycle feeds the prescaler
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.ext_q = t.ext_clk;
		s_nxt.gate_q = t.gate_pin;
		run = t.on && !(t.idle && t.idle_stop);
		if (t.ext_sel)
			src = t.ext_clk && !s_r.ext_q;
		else if (t.gate_en)
			src = t.gate_pin;
		else
			src = 1'b1;
		raw = run && src && (s_r.pcnt == ps_end);
		// prescaler clears on a count write or while off
		if (t.clr || !t.on)
			s_nxt.pcnt = '0;
		else if (run && src)
			s_nxt.pcnt = raw ? '0 : s_r.pcnt + 1'b1;
		// gate falls end an accumulation; only meaningful on internal clock
		s_nxt.gate_fall = t.on && t.gate_en && !t.ext_sel && s_r.gate_q && !t.gate_pin;
		s_nxt.tick = raw;
	end

	// low timer retimes its prescaler output, high timer passes it straight
	assign t.tick = SYNC_OUT ? s_r.tick : raw;
	assign t.gate_fall = s_r.gate_fall;

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s_r <= '0;
		else if (i_clk_en)
			s_r <= s_nxt;
	end
endmodule
`default_nettype wire

// file: bench/timer_properties.sv
// port-level apb and interrupt checks of the paired timer
// assumes byte address is four times the index and a zero-wait slave
`timescale 1ns/100ps
`default_nettype none
`include "paired_timer_params.svh"
module timer_properties #(
	parameter int ADDR_W = 12
)(
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_irq
);
	logic [9:0] idx;
	logic acc;
	logic rda;
	logic hit;
	// decode once so every property sees the same index
	assign idx = i_paddr[11:2];
	assign acc = i_psel && i_penable;
	assign rda = acc && !i_pwrite;
	assign hit = idx inside {`IDX_LO_CNT, `IDX_HOLD, `IDX_HI_CNT, `IDX_LO_PER, `IDX_HI_PER,
		`IDX_LO_CON, `IDX_HI_CON, `IDX_IRQ_STAT, `IDX_IRQ_MASK};
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_arst_n);
	sequence xfer_s;
		i_psel && !i_penable ##1 acc;
	endsequence
	sequence mask_off_s;
		acc && i_pwrite && idx == `IDX_IRQ_MASK && i_pwdata[1:0] == 2'h0;
	endsequence
	ready_const_a: assert property (xfer_s |-> o_pready) else $error("pready low");
	err_phase_a: assert property (o_pslverr |-> acc) else $error("pslverr outside access");
	err_mapped_a: assert property (acc && hit |-> !o_pslverr) else $error("pslverr on map");
	err_unmapped_a: assert property (rda && !hit |-> o_pslverr && o_prdata == 32'h0)
		else $error("unmapped read not refused");
	upper_zero_a: assert property (rda && hit |-> o_prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	lo_con_bits_a: assert property (rda && idx == `IDX_LO_CON |->
		(o_prdata[15:0] & ~`CON_LO_MASK) == 16'h0) else $error("low control spare bit");
	hi_con_bits_a: assert property (rda && idx == `IDX_HI_CON |->
		(o_prdata[15:0] & ~`CON_HI_MASK) == 16'h0) else $error("high control spare bit");
	stat_bits_a: assert property (rda && idx inside {`IDX_IRQ_STAT, `IDX_IRQ_MASK} |->
		o_prdata[31:2] == 30'h0) else $error("status spare bit");
	mask_off_a: assert property (mask_off_s |-> ##2 !o_irq) else $error("irq despite mask");
endmodule
bind paired_32bit_timer timer_properties #(.ADDR_W(ADDR_W)) props (.i_clk_sys(i_clk_sys),
	.i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .o_irq(o_irq));
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench of the paired timer: apb register calls and pin pulses
// assumes a zero-wait apb slave, byte address four times the index
`timescale 1ns/100ps
`default_nettype none
`include "paired_timer_params.svh"
module testbench;
	logic clk, clk_en, arst_n, psel, penable, pwrite, idle, pready, pslverr, irq;
	logic [1:0] ext;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int failures = 0;
	int comparisons = 0;
	paired_32bit_timer uut (.i_clk_sys(clk), .i_arst_n(arst_n), .i_clk_en(clk_en),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_idle(idle), .i_ext_clk_lo(ext[0]), .i_ext_clk_hi(ext[1]), .o_irq(irq));
	// free-running 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic end_sim;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one apb transfer; an idle edge follows so psel is never assigned twice at once
	task automatic xfer(input logic w, input logic [9:0] r, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {r, 2'h0};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [9:0] r, input logic [31:0] d);
		xfer(1'b1, r, d);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// n rising edges on one pin, two cycles high and two low each
	task automatic pulse(input int b, input int n);
		repeat (n)
		begin
			ext[b] <= 1'b1;
			repeat (2) @(posedge clk);
			ext[b] <= 1'b0;
			repeat (2) @(posedge clk);
		end
		repeat (4) @(posedge clk);
	endtask
	// watchdog: the whole run needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		failures++;
		end_sim();
	end
	// main sequence
	initial
	begin
		{arst_n, psel, penable, pwrite, idle, ext, paddr, pwdata} = '0;
		clk_en = 1'b1;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		xfer(1'b0, `IDX_LO_PER, 32'h0); chk(q, 32'h0000FFFF);
		xfer(1'b0, 10'h000, 32'h0); chk(q, 32'h0);
		wr(`IDX_HI_CON, 32'h8002);
		pulse(1, 5);
		xfer(1'b0, `IDX_HI_CNT, 32'h0); chk(q, 32'h5);
		wr(`IDX_LO_CON, 32'h8010);
		repeat (80) @(posedge clk);
		wr(`IDX_LO_CON, 32'h0);
		xfer(1'b0, `IDX_LO_CNT, 32'h0); chk({31'h0, q >= 32'h9 && q <= 32'hB}, 32'h1);
		wr(`IDX_LO_CNT, 32'h0);
		idle <= 1'b1;
		wr(`IDX_LO_CON, 32'hA000);
		repeat (20) @(posedge clk);
		xfer(1'b0, `IDX_LO_CNT, 32'h0); chk(q, 32'h0);
		idle <= 1'b0;
		repeat (20) @(posedge clk);
		wr(`IDX_LO_CON, 32'h0);
		xfer(1'b0, `IDX_LO_CNT, 32'h0); chk({31'h0, q >= 32'h10}, 32'h1);
		wr(`IDX_LO_CNT, 32'h0);
		wr(`IDX_LO_PER, 32'h4);
		// idle with idle stop clear must not stop the count
		idle <= 1'b1;
		wr(`IDX_LO_CON, 32'h8000);
		repeat (30) @(posedge clk);
		idle <= 1'b0;
		wr(`IDX_LO_CON, 32'h0);
		xfer(1'b0, `IDX_LO_CNT, 32'h0); chk({31'h0, q <= 32'h4}, 32'h1);
		xfer(1'b0, `IDX_IRQ_STAT, 32'h0); chk(q, 32'h1);
		wr(`IDX_IRQ_STAT, 32'h3);
		wr(`IDX_HI_PER, 32'h1);
		wr(`IDX_LO_PER, 32'h8);
		wr(`IDX_LO_CON, 32'h0008);
		wr(`IDX_HOLD, 32'h1);
		wr(`IDX_LO_CNT, 32'h0);
		xfer(1'b0, `IDX_HI_CNT, 32'h0); chk(q, 32'h1);
		wr(`IDX_HOLD, 32'h7);
		xfer(1'b0, `IDX_LO_CNT, 32'h0); chk(q, 32'h0);
		xfer(1'b0, `IDX_HOLD, 32'h0); chk(q, 32'h1);
		// high control left on with external clock and pulsed: paired mode must ignore it
		wr(`IDX_LO_CON, 32'h8008);
		pulse(1, 10);
		wr(`IDX_LO_CON, 32'h0);
		xfer(1'b0, `IDX_LO_CNT, 32'h0); chk({31'h0, q < 32'h30}, 32'h1);
		xfer(1'b0, `IDX_HOLD, 32'h0); chk(q, 32'h0);
		xfer(1'b0, `IDX_IRQ_STAT, 32'h0); chk(q, 32'h2);
		wr(`IDX_IRQ_MASK, 32'h1); chk({31'h0, irq}, 32'h0);
		wr(`IDX_IRQ_MASK, 32'h2); chk({31'h0, irq}, 32'h1);
		wr(`IDX_IRQ_MASK, 32'h0); chk({31'h0, irq}, 32'h0);
		wr(`IDX_IRQ_STAT, 32'h2);
		xfer(1'b0, `IDX_IRQ_STAT, 32'h0); chk(q, 32'h0);
		wr(`IDX_HOLD, 32'h0);
		wr(`IDX_LO_CNT, 32'h0);
		wr(`IDX_LO_CON, 32'h800A);
		pulse(0, 5);
		wr(`IDX_LO_CON, 32'h0);
		xfer(1'b0, `IDX_LO_CNT, 32'h0); chk(q, 32'h5);
		xfer(1'b0, `IDX_HOLD, 32'h0); chk(q, 32'h0);
		// prescaler 1:64: two ticks within 131 enabled cycles
		wr(`IDX_LO_CNT, 32'h0);
		wr(`IDX_LO_CON, 32'h8020);
		repeat (128) @(posedge clk);
		wr(`IDX_LO_CON, 32'h0);
		xfer(1'b0, `IDX_LO_CNT, 32'h0); chk(q, 32'h2);
		// paired gate: counts while the low pin is high, its fall flags the pair
		wr(`IDX_LO_CNT, 32'h0);
		wr(`IDX_LO_CON, 32'h8048);
		pulse(0, 1);
		wr(`IDX_LO_CON, 32'h0);
		xfer(1'b0, `IDX_LO_CNT, 32'h0); chk(q, 32'h2);
		xfer(1'b0, `IDX_IRQ_STAT, 32'h0); chk(q, 32'h2);
		// a write while the clock enable is low must not land
		clk_en <= 1'b0;
		wr(`IDX_LO_CON, 32'h8000);
		clk_en <= 1'b1;
		xfer(1'b0, `IDX_LO_CON, 32'h0); chk(q, 32'h0);
		end_sim();
	end
endmodule
`default_nettype wire
